/* design/lpt_pkg.sv */
package lpt_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int CODE_W = 4;
    localparam int SEL_W  = 2;
    localparam int NSRC   = 4;

    // Byte offsets of the registers
    localparam logic [ADDR_W-1:0] OFS_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PRESC = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MATCH = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 4'hc;

    // Control register layout
    localparam int CTRL_ON_BIT   = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_FREE_BIT = 2;
    localparam int CTRL_POL_BIT  = 3;
    localparam int CTRL_PIN_LSB  = 4;
    localparam int CTRL_FLAG_BIT = 7;

    // Prescale register layout
    localparam int PSR_SRC_LSB  = 0;
    localparam int PSR_BYP_BIT  = 2;
    localparam int PSR_CODE_LSB = 3;

    // Byte lanes
    localparam int LANE0 = 0;
    localparam int LANE1 = 1;

    localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
    localparam logic [CNT_W-1:0]  MATCH_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [31:0]       DIV_BASE  = 32'h0000_0002;
    localparam logic [31:0]       ONE_32    = 32'h0000_0001;

    typedef enum logic [1:0] {
        LPT_IDLE = 2'b01,
        LPT_ACK  = 2'b10
    } lpt_phase_t;

    typedef struct packed {
        lpt_phase_t              phase;
        logic                    bus_wait;
        logic [DATA_W-1:0]       rdata;
        logic                    timer_on;
        logic                    pulse_mode;
        logic                    free_run;
        logic                    pin_pol;
        logic [SEL_W-1:0]        pin_sel;
        logic [CODE_W-1:0]       div_code;
        logic                    filter_bypass;
        logic [SEL_W-1:0]        source_clock_select;
        logic [CNT_W-1:0]        match_reg;
        logic [CNT_W-1:0]        count_reg;
        logic [CNT_W-1:0]        hold_reg;
        logic                    match_flag;
        logic                    trigger;
        logic                    src_prev;
        logic                    pin_prev;
        logic [CNT_W-1:0]        presc_cnt;
        logic                    filt_out;
        logic [CNT_W-1:0]        filt_cnt;
    } lpt_state_t;

    localparam lpt_state_t LPT_STATE_RST = '{
        phase:               LPT_IDLE,
        bus_wait:            1'b1,
        rdata:               32'h0000_0000,
        timer_on:            1'b0,
        pulse_mode:          1'b0,
        free_run:            1'b0,
        pin_pol:             1'b0,
        pin_sel:             2'h0,
        div_code:            4'h0,
        filter_bypass:       1'b0,
        source_clock_select: 2'h0,
        match_reg:           16'h0000,
        count_reg:           16'h0000,
        hold_reg:            16'h0000,
        match_flag:          1'b0,
        trigger:             1'b0,
        src_prev:            1'b0,
        pin_prev:            1'b1,
        presc_cnt:           16'h0000,
        filt_out:            1'b1,
        filt_cnt:            16'h0000
    };

endpackage

/* design/lpt_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module lpt_timer
    import lpt_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [NSRC-1:0]   src_clk,
    input  wire logic [NSRC-1:0]   pulse_in,
    output logic                   hw_trigger
);

    lpt_state_t        st_reg;
    lpt_state_t        st_next;
    logic              wr_go;
    logic              sel_clk;
    logic              src_rise;
    logic              pin_lvl;
    logic              inc;
    logic              hit;
    logic              keep_trig;
    logic [31:0]       wide_mask;
    logic [31:0]       wide_len;
    logic [CNT_W-1:0]  div_mask;
    logic [CNT_W-1:0]  filt_len;
    logic [CNT_W-1:0]  presc_inc;

    assign avs_readdata    = st_reg.rdata;
    assign avs_waitrequest = st_reg.bus_wait;
    assign hw_trigger      = st_reg.trigger;

    always_comb begin
        st_next   = st_reg;
        wr_go     = avs_write && !st_reg.bus_wait;
        sel_clk   = src_clk[st_reg.source_clock_select];
        src_rise  = sel_clk && !st_reg.src_prev;
        pin_lvl   = pulse_in[st_reg.pin_sel] ^ st_reg.pin_pol;
        wide_mask = (DIV_BASE << st_reg.div_code) - ONE_32;
        wide_len  = ONE_32 << st_reg.div_code;
        div_mask  = wide_mask[CNT_W-1:0];
        filt_len  = wide_len[CNT_W-1:0];
        presc_inc = st_reg.presc_cnt + CNT_ONE;
        inc       = 1'b0;
        hit       = 1'b0;
        keep_trig = (st_reg.match_reg == CNT_ZERO) && !st_reg.free_run;

        // Bus handshake: answer one cycle after the request appears
        case (st_reg.phase)
            LPT_IDLE: begin
                if (avs_read || avs_write) begin
                    st_next.phase    = LPT_ACK;
                    st_next.bus_wait = 1'b0;
                end
            end
            LPT_ACK: begin
                st_next.phase    = LPT_IDLE;
                st_next.bus_wait = 1'b1;
            end
            default: begin
                st_next.phase    = LPT_IDLE;
                st_next.bus_wait = 1'b1;
            end
        endcase

        // Read data is built while waitrequest is still high
        if (st_reg.phase == LPT_IDLE && avs_read) begin
            st_next.rdata = DATA_ZERO;
            if (avs_address == OFS_CTRL) begin
                st_next.rdata[CTRL_ON_BIT]   = st_reg.timer_on;
                st_next.rdata[CTRL_MODE_BIT] = st_reg.pulse_mode;
                st_next.rdata[CTRL_FREE_BIT] = st_reg.free_run;
                st_next.rdata[CTRL_POL_BIT]  = st_reg.pin_pol;
                st_next.rdata[CTRL_PIN_LSB +: SEL_W] = st_reg.pin_sel;
                st_next.rdata[CTRL_FLAG_BIT] = st_reg.match_flag;
            end else if (avs_address == OFS_PRESC) begin
                st_next.rdata[PSR_SRC_LSB +: SEL_W] =
                    st_reg.source_clock_select;
                st_next.rdata[PSR_BYP_BIT] = st_reg.filter_bypass;
                st_next.rdata[PSR_CODE_LSB +: CODE_W] = st_reg.div_code;
            end else if (avs_address == OFS_MATCH) begin
                st_next.rdata[CNT_W-1:0] = st_reg.match_reg;
            end else if (avs_address == OFS_COUNT) begin
                st_next.rdata[CNT_W-1:0] = st_reg.hold_reg;
            end
        end

        st_next.src_prev = sel_clk;

        // Time base: raw clock, prescaler, raw pin or glitch filter
        if (st_reg.timer_on) begin
            if (!st_reg.pulse_mode) begin
                if (st_reg.filter_bypass) begin
                    inc = src_rise;
                end else if (src_rise) begin
                    st_next.presc_cnt = presc_inc;
                    inc = (st_reg.presc_cnt & div_mask) == div_mask;
                end
            end else if (st_reg.filter_bypass) begin
                st_next.pin_prev = pin_lvl;
                inc = pin_lvl && !st_reg.pin_prev;
            end else if (src_rise) begin
                if (pin_lvl == st_reg.filt_out) begin
                    st_next.filt_cnt = CNT_ZERO;
                end else if (st_reg.filt_cnt == filt_len - CNT_ONE) begin
                    st_next.filt_out = pin_lvl;
                    st_next.filt_cnt = CNT_ZERO;
                    inc = pin_lvl;
                end else begin
                    st_next.filt_cnt = st_reg.filt_cnt + CNT_ONE;
                end
            end
        end

        // Counter, compare flag and trigger
        if (inc) begin
            hit = st_reg.count_reg == st_reg.match_reg;
            if (hit) begin
                st_next.match_flag = 1'b1;
                st_next.trigger    = 1'b1;
                st_next.count_reg  = st_reg.free_run ?
                    st_reg.count_reg + CNT_ONE : CNT_ZERO;
            end else begin
                st_next.count_reg = st_reg.count_reg + CNT_ONE;
                if (!keep_trig) begin
                    st_next.trigger = 1'b0;
                end
            end
        end

        // Register writes take effect one edge after the wait ends, as waitrequest rises again
        if (wr_go) begin
            if (avs_address == OFS_CTRL) begin
                if (avs_byteenable[LANE0]) begin
                    st_next.timer_on   = avs_writedata[CTRL_ON_BIT];
                    st_next.pulse_mode = avs_writedata[CTRL_MODE_BIT];
                    st_next.free_run   = avs_writedata[CTRL_FREE_BIT];
                    st_next.pin_pol    = avs_writedata[CTRL_POL_BIT];
                    st_next.pin_sel    =
                        avs_writedata[CTRL_PIN_LSB +: SEL_W];
                    // Write one clears, a same-cycle compare still sets
                    if (avs_writedata[CTRL_FLAG_BIT] && !hit) begin
                        st_next.match_flag = 1'b0;
                    end
                end
            end else if (avs_address == OFS_PRESC) begin
                if (avs_byteenable[LANE0]) begin
                    st_next.source_clock_select =
                        avs_writedata[PSR_SRC_LSB +: SEL_W];
                    st_next.filter_bypass =
                        avs_writedata[PSR_BYP_BIT];
                    st_next.div_code =
                        avs_writedata[PSR_CODE_LSB +: CODE_W];
                end
            end else if (avs_address == OFS_MATCH) begin
                if (avs_byteenable[LANE0]) begin
                    st_next.match_reg[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[LANE1]) begin
                    st_next.match_reg[15:8] = avs_writedata[15:8];
                end
            end else if (avs_address == OFS_COUNT) begin
                st_next.hold_reg = st_reg.count_reg;
            end
        end

        // Disabled timer holds its internal logic in reset
        if (!st_reg.timer_on) begin
            st_next.count_reg  = CNT_ZERO;
            st_next.match_flag = 1'b0;
            st_next.trigger    = 1'b0;
            st_next.presc_cnt  = CNT_ZERO;
            st_next.filt_cnt   = CNT_ZERO;
            st_next.filt_out   = 1'b1;
            st_next.pin_prev   = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= LPT_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_count_write;
        wr_go && avs_address == OFS_COUNT;
    endsequence

    sequence s_compare;
        inc && st_reg.count_reg == st_reg.match_reg && st_reg.timer_on;
    endsequence

    sequence s_plain_step;
        inc && st_reg.count_reg != st_reg.match_reg && st_reg.timer_on;
    endsequence

    // A tick must come exactly where the low prescaler bits wrap
    property p_prescale_tick;
        st_reg.timer_on && !st_reg.pulse_mode && !st_reg.filter_bypass
            && inc |=> (st_reg.presc_cnt & $past(div_mask)) == CNT_ZERO;
    endproperty
    a_prescale_tick: assert property (p_prescale_tick)
        else $error("prescaler tick off its divide boundary");

    property p_filter_hold;
        st_reg.timer_on && st_reg.pulse_mode && !st_reg.filter_bypass
            && !$past(!st_reg.timer_on) && $changed(st_reg.filt_out)
            |-> $past(st_reg.filt_cnt) == $past(filt_len) - CNT_ONE;
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("filter output changed before its hold count");

    property p_bypass_count;
        st_reg.timer_on && st_reg.filter_bypass && inc && !wr_go
            |=> st_reg.count_reg == $past(st_reg.count_reg) + CNT_ONE
            || st_reg.count_reg == CNT_ZERO;
    endproperty
    a_bypass_count: assert property (p_bypass_count)
        else $error("bypassed count did not advance");

    property p_count_cause;
        st_reg.timer_on && $past(st_reg.timer_on)
            && st_reg.count_reg != $past(st_reg.count_reg)
            |-> $past(inc);
    endproperty
    a_count_cause: assert property (p_count_cause)
        else $error("count moved without a time base event");

    property p_clock_select;
        $stable(st_reg.source_clock_select) |-> st_reg.src_prev
            == $past(src_clk[st_reg.source_clock_select]);
    endproperty
    a_clock_select: assert property (p_clock_select)
        else $error("wrong source clock selected");

    property p_reserved_zero;
        !avs_waitrequest && avs_read && avs_address != OFS_CTRL
            |-> avs_readdata[DATA_W-1:CNT_W] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved read bits not zero");

    property p_flag_set;
        s_compare |=> st_reg.match_flag && hw_trigger;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("compare did not set flag and trigger");

    property p_zero_match_hold;
        hw_trigger && st_reg.timer_on && st_reg.match_reg == CNT_ZERO
            && !st_reg.free_run |=> hw_trigger;
    endproperty
    a_zero_match_hold: assert property (p_zero_match_hold)
        else $error("zero match trigger dropped while enabled");

    property p_disable_clears;
        !st_reg.timer_on |=> st_reg.count_reg == CNT_ZERO
            && !st_reg.match_flag && !hw_trigger;
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("disabled timer kept count or flag");

    property p_match_reset;
        s_compare ##0 !st_reg.free_run |=> st_reg.count_reg == CNT_ZERO;
    endproperty
    a_match_reset: assert property (p_match_reset)
        else $error("count not reset on compare");

    property p_capture;
        s_count_write |=> st_reg.hold_reg == $past(st_reg.count_reg);
    endproperty
    a_capture: assert property (p_capture)
        else $error("count write did not capture live count");

    property p_answer;
        st_reg.phase == LPT_IDLE && (avs_read || avs_write)
            |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer not one cycle after request");

    property p_trigger_drop;
        s_plain_step ##0 (st_reg.match_reg != CNT_ZERO || st_reg.free_run)
            |=> !hw_trigger;
    endproperty
    a_trigger_drop: assert property (p_trigger_drop)
        else $error("trigger held past the next increment");

    property p_flag_clear;
        wr_go && avs_address == OFS_CTRL && avs_byteenable[LANE0]
            && avs_writedata[CTRL_FLAG_BIT]
            && !(inc && st_reg.count_reg == st_reg.match_reg)
            |=> !st_reg.match_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("write one did not clear the match flag");

    property p_reserved_presc;
        !avs_waitrequest && avs_read && avs_address == OFS_PRESC
            |-> avs_readdata[DATA_W-1:PSR_CODE_LSB+CODE_W] == '0;
    endproperty
    a_reserved_presc: assert property (p_reserved_presc)
        else $error("prescale reserved bits not zero");

    // The holding register must only move on a count write
    property p_hold_idle;
        !(wr_go && avs_address == OFS_COUNT)
            |=> $stable(st_reg.hold_reg);
    endproperty
    a_hold_idle: assert property (p_hold_idle)
        else $error("holding register moved without a count write");

    property p_filter_start;
        !st_reg.timer_on |=> st_reg.filt_out && st_reg.pin_prev;
    endproperty
    a_filter_start: assert property (p_filter_start)
        else $error("disabled timer left input stage deasserted");

endmodule

`default_nettype wire

/* dv/lpt_src_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lpt_src_model
    import lpt_pkg::*;
(
    input  wire logic            mclk,
    output logic      [NSRC-1:0] src_clk,
    output logic      [NSRC-1:0] pulse_in
);
    initial begin
        src_clk  = '0;
        pulse_in = '0;
    end

    // Source clocks stand low between bursts
    task automatic rises(input int idx, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk) src_clk[idx] <= 1'b1;
            @(posedge mclk);
            @(posedge mclk) src_clk[idx] <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic pin(input int idx, input logic lvl);
        @(posedge mclk) pulse_in[idx] <= lvl;
        @(posedge mclk);
    endtask
endmodule

`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench
    import lpt_pkg::*;
;
    logic              mclk;
    logic              reset_n;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    wire  [NSRC-1:0]   src_clk;
    wire  [NSRC-1:0]   pulse_in;
    logic              hw_trigger;
    logic [DATA_W-1:0] rd;
    int                error_cnt;
    int                compares;

    lpt_timer dut_u (
        .mclk            (mclk),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .src_clk         (src_clk),
        .pulse_in        (pulse_in),
        .hw_trigger      (hw_trigger)
    );

    lpt_src_model src_u (
        .mclk     (mclk),
        .src_clk  (src_clk),
        .pulse_in (pulse_in)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic test_done;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (avs_waitrequest !== 1'b0) begin
            chk("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
            test_done;
        end else begin
            q = avs_readdata;
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp,
                        input string nm);
        bus(1'b0, a, 32'h0000_0000, rd);
        chk(nm, rd, exp);
    endtask

    task automatic cnt_chk(input logic [31:0] exp);
        wr(OFS_COUNT, 32'h0000_0000);
        rchk(OFS_COUNT, exp, "count");
    endtask

    task automatic trig(input logic exp);
        @(negedge mclk);
        chk("trigger", {31'h0, hw_trigger}, {31'h0, exp});
    endtask

    function automatic logic [31:0] ctl(input int md, fr, pol,
                                        input logic [1:0] pn);
        return {26'h0, pn, 1'(pol), 1'(fr), 1'(md), 1'b0};
    endfunction

    function automatic logic [31:0] prescale_reg(input logic [3:0] c,
                                        input logic b, input logic [1:0] s);
        return {25'h0, c, b, s};
    endfunction

    // Configuration is only touched with the timer stopped
    task automatic cfg(input logic [31:0] p, c, m);
        wr(OFS_CTRL, c);
        wr(OFS_PRESC, p);
        wr(OFS_MATCH, m);
        wr(OFS_CTRL, c | 32'h0000_0001);
    endtask

    task automatic t_regs;
        rchk(OFS_CTRL, 32'h0, "ctrl rst");
        rchk(OFS_PRESC, 32'h0, "psr rst");
        rchk(OFS_MATCH, 32'h0, "match rst");
        wr(OFS_PRESC, 32'hffff_ffff);
        rchk(OFS_PRESC, 32'h0000_007f, "psr");
        wr(OFS_MATCH, 32'hffff_ffff);
        rchk(OFS_MATCH, 32'h0000_ffff, "match");
        wr(4'h1, 32'hffff_ffff);
        rchk(4'h1, 32'h0, "unmapped");
        wr(OFS_COUNT, 32'hffff_ffff);
        rchk(OFS_COUNT, 32'h0, "count off");
    endtask

    task automatic t_sel;
        for (int s = 0; s < NSRC; s++) begin
            cfg(prescale_reg(4'h0, 1'b1, 2'(s)), ctl(0, 0, 0, 2'h0), 32'hffff);
            src_u.rises(s, 3 + s);
            src_u.rises((s + 1) % NSRC, 2);
            cnt_chk(32'(3 + s));
        end
    endtask

    task automatic t_presc;
        for (int c = 0; c < 3; c++) begin
            cfg(prescale_reg(4'(c), 1'b0, 2'h1), ctl(0, 0, 0, 2'h0), 32'hffff);
            src_u.rises(1, 3 * (2 << c) + 1);
            cnt_chk(32'h3);
        end
    endtask

    task automatic t_pulse_byp;
        for (int p = 0; p < 2; p++) begin
            src_u.pin(1 + 2 * p, !p);
            cfg(prescale_reg(4'h0, 1'b1, 2'h0), ctl(1, 0, p, 2'(1 + 2 * p)),
                32'hffff);
            for (int k = 0; k < 3; k++) begin
                src_u.pin(1 + 2 * p, 1'(p));
                src_u.pin(1 + 2 * p, !p);
            end
            cnt_chk(32'h3);
        end
    endtask

    task automatic t_filter;
        src_u.pin(0, 1'b0);
        cfg(prescale_reg(4'h2, 1'b0, 2'h0), ctl(1, 0, 0, 2'h0), 32'hffff);
        src_u.rises(0, 4);
        src_u.pin(0, 1'b1);
        src_u.rises(0, 3);
        src_u.pin(0, 1'b0);
        src_u.rises(0, 1);
        src_u.pin(0, 1'b1);
        src_u.rises(0, 3);
        cnt_chk(32'h0);
        src_u.rises(0, 1);
        cnt_chk(32'h1);
    endtask

    task automatic t_match;
        cfg(prescale_reg(4'h0, 1'b1, 2'h0), ctl(0, 0, 0, 2'h0), 32'h3);
        src_u.rises(0, 3);
        cnt_chk(32'h3);
        trig(1'b0);
        src_u.rises(0, 1);
        trig(1'b1);
        rchk(OFS_CTRL, 32'h0000_0081, "flag");
        cnt_chk(32'h0);
        src_u.rises(0, 1);
        trig(1'b0);
        wr(OFS_CTRL, 32'h0000_0081);
        rchk(OFS_CTRL, 32'h0000_0001, "flag clr");
        cfg(prescale_reg(4'h0, 1'b1, 2'h0), ctl(0, 1, 0, 2'h0), 32'h1);
        src_u.rises(0, 2);
        rchk(OFS_CTRL, 32'h0000_0085, "flag free");
        cnt_chk(32'h2);
        wr(OFS_CTRL, 32'h0000_0004);
        rchk(OFS_CTRL, 32'h0000_0004, "flag off");
        cnt_chk(32'h0);
        cfg(prescale_reg(4'h0, 1'b1, 2'h0), ctl(0, 0, 0, 2'h0), 32'h0);
        src_u.rises(0, 1);
        trig(1'b1);
        src_u.rises(0, 3);
        trig(1'b1);
        cnt_chk(32'h0);
        wr(OFS_CTRL, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        trig(1'b0);
    endtask

    initial begin
        reset_n        = 1'b0;
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = '0;
        avs_byteenable = 4'hf;
        error_cnt      = 0;
        compares       = 0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs;
        t_sel;
        t_presc;
        t_pulse_byp;
        t_filter;
        t_match;
        test_done;
    end
endmodule

`default_nettype wire
